// ===== src/pcp_cfg_map.vh
// Function
// RULE1: Power field 01 powers down, 00 runs.
// RULE2: Bypass bit set skips the VCO divider.
// RULE3: Source bit 0 routes external CLK input.
// RULE4: Polarity bit 0 positive, 1 negative.
// RULE5: Settings apply only after update write 0x01.
// RULE6: Two-bit field selects antibacklash pulse width.
// RULE7: Pump mode: hiz, normal, up, down.
// RULE8: Pump current: eight steps, 600 uA-4.8 mA.
// RULE9: Software calibrates VCO on setup, frequency change.
// RULE10: Reference present, divider running during calibration.
// RULE11: External oscillator below 1600 MHz: run, bypass.
// RULE12: Polarity matters only with external oscillator.
// RULE13: Calibration bit cleared, committed, set, committed.
// RULE14: Source bit 1 routes internal oscillator.
// RULE15: Staged fields all move active on commit.
`ifndef PCP_CFG_MAP_VH
`define PCP_CFG_MAP_VH

// =====================================================
// Register indices (byte address is four times index)
`define PCP_IDX_PWR_POL_PUMP 10'h010
`define PCP_IDX_ABL_WIDTH 10'h017
`define PCP_IDX_VCO_CAL 10'h018
`define PCP_IDX_DIST_SRC 10'h1e1
`define PCP_IDX_COMMIT 10'h232
`define PCP_IDX_CP_CURRENT 10'h300
`define PCP_IDX_ACTIVE_STATUS 10'h301

// =====================================================
// Field positions
`define PCP_F_PWR_LO 0
`define PCP_F_PWR_HI 1
`define PCP_F_CPMODE_LO 4
`define PCP_F_CPMODE_HI 6
`define PCP_F_POL 7
`define PCP_F_ABL_LO 0
`define PCP_F_ABL_HI 1
`define PCP_F_CAL 0
`define PCP_F_BYPASS 0
`define PCP_F_SRC 1
`define PCP_F_COMMIT 0
`define PCP_F_CPCUR_LO 0
`define PCP_F_CPCUR_HI 2

// =====================================================
// Encodings and reset values
`define PCP_PWR_RUN 2'h0
`define PCP_PWR_DOWN 2'h1
`define PCP_RST_PWR 2'h1
`define PCP_RST_POL 1'h0
`define PCP_RST_CPMODE 3'h0
`define PCP_RST_ABL 2'h0
`define PCP_RST_CAL 1'h0
`define PCP_RST_BYPASS 1'h0
`define PCP_RST_SRC 1'h0
`define PCP_RST_CPCUR 3'h0
`define PCP_CP_HIZ 3'h0
`define PCP_CP_UP 3'h1
`define PCP_CP_DOWN 3'h2
`define PCP_CP_NORMAL 3'h3
`define PCP_CP_STEP_UA 13'h0258

// =====================================================
// Bus answers
`define PCP_RESP_OKAY 2'h0
`define PCP_RESP_SLVERR 2'h2

`endif

// ===== src/pcp_cfg_top.v
`timescale 1ns/100ps
`include "pcp_cfg_map.vh"
// PLL and clock path configuration with AXI4-Lite access
module pcp_cfg_top (
	input wire mclk_in,
	input wire rst_in,
	input wire [11:0] s_axi_awaddr_in,
	input wire s_axi_awvalid_in,
	output reg s_axi_awready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	input wire s_axi_wvalid_in,
	output reg s_axi_wready_out,
	output reg [1:0] s_axi_bresp_out,
	output reg s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [11:0] s_axi_araddr_in,
	input wire s_axi_arvalid_in,
	output reg s_axi_arready_out,
	output reg [31:0] s_axi_rdata_out,
	output reg [1:0] s_axi_rresp_out,
	output reg s_axi_rvalid_out,
	input wire s_axi_rready_in,
	output reg pll_power_down_out,
	output reg pll_running_out,
	output reg div_bypass_out,
	output reg src_internal_osc_out,
	output reg src_ext_clk_out,
	output reg pfd_negative_out,
	output reg [1:0] abl_width_out,
	output reg cp_hiz_out,
	output reg cp_normal_out,
	output reg cp_force_up_out,
	output reg cp_force_down_out,
	output reg [2:0] cp_current_code_out,
	output reg [12:0] cp_current_ua_out,
	output reg vco_cal_start_out
);

	// =====================================================
	// Byte addresses
	localparam [11:0] A_PPC = {`PCP_IDX_PWR_POL_PUMP, 2'b00};
	localparam [11:0] A_ABL = {`PCP_IDX_ABL_WIDTH, 2'b00};
	localparam [11:0] A_CAL = {`PCP_IDX_VCO_CAL, 2'b00};
	localparam [11:0] A_SRC = {`PCP_IDX_DIST_SRC, 2'b00};
	localparam [11:0] A_COMMIT = {`PCP_IDX_COMMIT, 2'b00};
	localparam [11:0] A_CPCUR = {`PCP_IDX_CP_CURRENT, 2'b00};
	localparam [11:0] A_STAT = {`PCP_IDX_ACTIVE_STATUS, 2'b00};

	// =====================================================
	// Write channel state
	reg aw_held, w_held, w_lane0, next_aw_held, next_w_held, next_bvalid;
	reg [11:0] aw_addr;
	reg [31:0] w_data;
	wire aw_take, w_take, wr_exec, wr_ok, commit, wr_ppc, wr_abl, wr_cal, wr_src, wr_cpcur;
	wire [11:0] wr_word;

	// Field copies
	wire [1:0] pwr_s, pwr_a, abl_s, abl_a;
	wire [2:0] cpm_s, cpm_a, cur_s, cur_a;
	wire pol_s, pol_a, cal_s, cal_a, byp_s, byp_a, src_s, src_a;
	reg cal_a_q;

	// Read channel state
	reg next_rvalid;
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;
	wire ar_take;
	wire [11:0] rd_word;

	assign aw_take = s_axi_awvalid_in & s_axi_awready_out;
	assign w_take = s_axi_wvalid_in & s_axi_wready_out;
	assign wr_exec = aw_held & w_held & ~s_axi_bvalid_out;
	assign wr_word = {aw_addr[11:2], 2'b00};
	assign wr_ok = wr_exec & w_lane0;
	assign rd_word = {s_axi_araddr_in[11:2], 2'b00};
	assign ar_take = s_axi_arvalid_in & s_axi_arready_out;

	// Per-register write strobes into staging copies
	assign wr_ppc = wr_ok & (wr_word == A_PPC);
	assign wr_abl = wr_ok & (wr_word == A_ABL);
	assign wr_cal = wr_ok & (wr_word == A_CAL);
	assign wr_src = wr_ok & (wr_word == A_SRC);
	assign wr_cpcur = wr_ok & (wr_word == A_CPCUR);
	// Update write with bit 0 set commits everything
	assign commit = wr_ok & (wr_word == A_COMMIT) & w_data[`PCP_F_COMMIT]; // RULE5

	// =====================================================
	// Write address and data capture, either order
	always @* begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_bvalid = s_axi_bvalid_out;
		if (aw_take) begin
			next_aw_held = 1'b1;
		end
		if (w_take) begin
			next_w_held = 1'b1;
		end
		if (wr_exec) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
		end else if (s_axi_bvalid_out & s_axi_bready_in) begin
			next_bvalid = 1'b0;
		end
	end

	// Write channel registers
	always @(posedge mclk_in) begin
		if (rst_in) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h00000000;
			w_lane0 <= 1'b0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= `PCP_RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			s_axi_bvalid_out <= next_bvalid;
			s_axi_awready_out <= ~next_aw_held & ~next_bvalid;
			s_axi_wready_out <= ~next_w_held & ~next_bvalid;
			if (aw_take) begin
				aw_addr <= s_axi_awaddr_in;
			end
			if (w_take) begin
				w_data <= s_axi_wdata_in;
				w_lane0 <= s_axi_wstrb_in[0];
			end
			if (wr_exec) begin
				case (wr_word)
					A_PPC, A_ABL, A_CAL, A_SRC, A_COMMIT, A_CPCUR, A_STAT: begin
						s_axi_bresp_out <= `PCP_RESP_OKAY;
					end
					default: begin
						s_axi_bresp_out <= `PCP_RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// =====================================================
	// Staged fields, one cell each
	pcp_stage_cell #(.W(2), .RST(`PCP_RST_PWR)) u_pwr (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.wr_in(wr_ppc),
		.wdata_in(w_data[`PCP_F_PWR_HI:`PCP_F_PWR_LO]),
		.commit_in(commit),
		.staged_out(pwr_s),
		.active_out(pwr_a)
	);

	pcp_stage_cell #(.W(1), .RST(`PCP_RST_POL)) u_pol (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.wr_in(wr_ppc),
		.wdata_in(w_data[`PCP_F_POL]),
		.commit_in(commit),
		.staged_out(pol_s),
		.active_out(pol_a)
	);

	pcp_stage_cell #(.W(3), .RST(`PCP_RST_CPMODE)) u_cpm (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.wr_in(wr_ppc),
		.wdata_in(w_data[`PCP_F_CPMODE_HI:`PCP_F_CPMODE_LO]),
		.commit_in(commit),
		.staged_out(cpm_s),
		.active_out(cpm_a)
	);

	pcp_stage_cell #(.W(2), .RST(`PCP_RST_ABL)) u_abl (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.wr_in(wr_abl),
		.wdata_in(w_data[`PCP_F_ABL_HI:`PCP_F_ABL_LO]),
		.commit_in(commit),
		.staged_out(abl_s),
		.active_out(abl_a)
	);

	pcp_stage_cell #(.W(1), .RST(`PCP_RST_CAL)) u_cal (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.wr_in(wr_cal),
		.wdata_in(w_data[`PCP_F_CAL]),
		.commit_in(commit),
		.staged_out(cal_s),
		.active_out(cal_a)
	);

	pcp_stage_cell #(.W(1), .RST(`PCP_RST_BYPASS)) u_byp (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.wr_in(wr_src),
		.wdata_in(w_data[`PCP_F_BYPASS]),
		.commit_in(commit),
		.staged_out(byp_s),
		.active_out(byp_a)
	);

	pcp_stage_cell #(.W(1), .RST(`PCP_RST_SRC)) u_src (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.wr_in(wr_src),
		.wdata_in(w_data[`PCP_F_SRC]),
		.commit_in(commit),
		.staged_out(src_s),
		.active_out(src_a)
	);

	pcp_stage_cell #(.W(3), .RST(`PCP_RST_CPCUR)) u_cur (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.wr_in(wr_cpcur),
		.wdata_in(w_data[`PCP_F_CPCUR_HI:`PCP_F_CPCUR_LO]),
		.commit_in(commit),
		.staged_out(cur_s),
		.active_out(cur_a)
	);

	// =====================================================
	// Read mux: setting registers show staged copy
	always @* begin
		next_rdata = 32'h00000000;
		next_rresp = `PCP_RESP_OKAY;
		case (rd_word)
			A_PPC: begin
				next_rdata[`PCP_F_PWR_HI:`PCP_F_PWR_LO] = pwr_s;
				next_rdata[`PCP_F_CPMODE_HI:`PCP_F_CPMODE_LO] = cpm_s;
				next_rdata[`PCP_F_POL] = pol_s;
			end
			A_ABL: begin
				next_rdata[`PCP_F_ABL_HI:`PCP_F_ABL_LO] = abl_s;
			end
			A_CAL: begin
				next_rdata[`PCP_F_CAL] = cal_s;
			end
			A_SRC: begin
				next_rdata[`PCP_F_BYPASS] = byp_s;
				next_rdata[`PCP_F_SRC] = src_s;
			end
			A_COMMIT: begin
				next_rdata = 32'h00000000; // Self-clearing
			end
			A_CPCUR: begin
				next_rdata[`PCP_F_CPCUR_HI:`PCP_F_CPCUR_LO] = cur_s;
			end
			A_STAT: begin
				next_rdata[13:0] = {cur_a, cal_a, abl_a, src_a, byp_a, pol_a, cpm_a, pwr_a};
			end
			default: begin
				next_rresp = `PCP_RESP_SLVERR;
			end
		endcase
	end

	// Read valid tracking
	always @* begin
		next_rvalid = s_axi_rvalid_out;
		if (ar_take) begin
			next_rvalid = 1'b1;
		end else if (s_axi_rvalid_out & s_axi_rready_in) begin
			next_rvalid = 1'b0;
		end
	end

	// Read channel registers
	always @(posedge mclk_in) begin
		if (rst_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= `PCP_RESP_OKAY;
		end else begin
			s_axi_rvalid_out <= next_rvalid;
			s_axi_arready_out <= ~next_rvalid;
			if (ar_take) begin
				s_axi_rdata_out <= next_rdata;
				s_axi_rresp_out <= next_rresp;
			end
		end
	end

	// =====================================================
	// Decode of active copy onto control outputs
	always @(posedge mclk_in) begin
		if (rst_in) begin
			pll_power_down_out <= 1'b1;
			pll_running_out <= 1'b0;
			div_bypass_out <= 1'b0;
			src_internal_osc_out <= 1'b0;
			src_ext_clk_out <= 1'b1;
			pfd_negative_out <= 1'b0;
			abl_width_out <= `PCP_RST_ABL;
			cp_hiz_out <= 1'b1;
			cp_normal_out <= 1'b0;
			cp_force_up_out <= 1'b0;
			cp_force_down_out <= 1'b0;
			cp_current_code_out <= `PCP_RST_CPCUR;
			cp_current_ua_out <= `PCP_CP_STEP_UA;
			cal_a_q <= `PCP_RST_CAL;
			vco_cal_start_out <= 1'b0;
		end else begin
			// Only 00 runs; 01 and unused codes power down
			pll_running_out <= (pwr_a == `PCP_PWR_RUN); // RULE1
			pll_power_down_out <= (pwr_a != `PCP_PWR_RUN); // RULE1
			div_bypass_out <= byp_a; // RULE2
			src_ext_clk_out <= ~src_a; // RULE3
			src_internal_osc_out <= src_a; // RULE14
			// Internal oscillator forces positive polarity
			pfd_negative_out <= pol_a & ~src_a; // RULE4 RULE12
			abl_width_out <= abl_a; // RULE6
			// Unused pump codes fall back to high impedance
			cp_normal_out <= (cpm_a == `PCP_CP_NORMAL); // RULE7
			cp_force_up_out <= (cpm_a == `PCP_CP_UP); // RULE7
			cp_force_down_out <= (cpm_a == `PCP_CP_DOWN); // RULE7
			cp_hiz_out <= (cpm_a != `PCP_CP_NORMAL) & (cpm_a != `PCP_CP_UP) &
				(cpm_a != `PCP_CP_DOWN); // RULE7
			// Nominal current is one step per code plus one
			cp_current_code_out <= cur_a; // RULE8
			cp_current_ua_out <= `PCP_CP_STEP_UA * {10'h000, cur_a} + `PCP_CP_STEP_UA; // RULE8
			// Calibration starts on committed 0 to 1 edge
			cal_a_q <= cal_a;
			vco_cal_start_out <= cal_a & ~cal_a_q; // RULE13
		end
	end

endmodule // pcp_cfg_top

// ===== src/pcp_stage_cell.v
`timescale 1ns/100ps
// Staging copy plus active copy of one field
module pcp_stage_cell #(
	parameter W = 1,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	input wire mclk_in,
	input wire rst_in,
	input wire wr_in,
	input wire [W-1:0] wdata_in,
	input wire commit_in,
	output reg [W-1:0] staged_out,
	output reg [W-1:0] active_out
);

	// Software writes land in the staging copy only
	always @(posedge mclk_in) begin
		if (rst_in) begin
			staged_out <= RST;
		end else if (wr_in) begin
			staged_out <= wdata_in;
		end
	end

	// Commit moves staged value to active copy
	always @(posedge mclk_in) begin
		if (rst_in) begin
			active_out <= RST;
		end else if (commit_in) begin
			active_out <= staged_out; // RULE15
		end
	end

endmodule // pcp_stage_cell

// ===== verification/pcp_cfg_monitor.sv
`timescale 1ns/100ps
// ==========
// Port checker
module pcp_cfg_monitor (
	input wire mclk_in,
	input wire rst_in,
	input wire s_axi_awready_out,
	input wire s_axi_wready_out,
	input wire s_axi_bvalid_out,
	input wire pll_power_down_out,
	input wire pll_running_out,
	input wire div_bypass_out,
	input wire src_internal_osc_out,
	input wire src_ext_clk_out,
	input wire pfd_negative_out,
	input wire [1:0] abl_width_out,
	input wire cp_hiz_out,
	input wire cp_normal_out,
	input wire cp_force_up_out,
	input wire cp_force_down_out,
	input wire [2:0] cp_current_code_out,
	input wire [12:0] cp_current_ua_out,
	input wire vco_cal_start_out
);
	reg bv1;
	reg bv2;
	// Settings that may move only after a commit
	wire [11:0] cfg = {pll_power_down_out, div_bypass_out, src_internal_osc_out, pfd_negative_out,
		abl_width_out, cp_normal_out, cp_force_up_out, cp_force_down_out, cp_current_code_out};
	// Delayed write answer marks the commit window
	always @(posedge mclk_in) begin
		if (rst_in) begin
			bv1 <= 1'b0;
			bv2 <= 1'b0;
		end else begin
			bv1 <= s_axi_bvalid_out;
			bv2 <= bv1;
		end
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	AST_PWR: assert property (pll_power_down_out != pll_running_out)
		else $error("power flags disagree");
	AST_SRC: assert property (src_internal_osc_out != src_ext_clk_out)
		else $error("source flags disagree");
	AST_POL: assert property (src_internal_osc_out |-> !pfd_negative_out)
		else $error("polarity with internal source");
	AST_CPMODE: assert property ($onehot({cp_hiz_out, cp_normal_out, cp_force_up_out, cp_force_down_out}))
		else $error("pump mode not one-hot");
	AST_CPUA: assert property (cp_current_ua_out == 13'h258 * (cp_current_code_out + 13'h1))
		else $error("pump current wrong");
	AST_CAL: assert property (vco_cal_start_out |-> (bv1 || bv2) ##1 !vco_cal_start_out)
		else $error("cal pulse wrong");
	AST_COMMIT: assert property ((!bv1 || bv2) |-> $stable(cfg))
		else $error("settings moved without commit");
	AST_REFUSE: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken during answer");
endmodule // pcp_cfg_monitor

bind pcp_cfg_top pcp_cfg_monitor u_pcp_cfg_monitor (.*);

// ===== verification/pcp_cfg_top_test.sv
`timescale 1ns/100ps
// ==========
// Register bank bench
module pcp_cfg_top_test;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [11:0] s_axi_awaddr_in = 12'h0, s_axi_araddr_in = 12'h0;
	logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in = 4'hf;
	logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
	logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, abl_width_out;
	logic pll_power_down_out, pll_running_out, div_bypass_out, src_internal_osc_out, src_ext_clk_out;
	logic pfd_negative_out, cp_hiz_out, cp_normal_out, cp_force_up_out, cp_force_down_out, vco_cal_start_out;
	logic [2:0] cp_current_code_out;
	logic [12:0] cp_current_ua_out;
	logic [33:0] exp_q[$];
	int miscompares = 0, num_checks = 0, pulses = 0, i;
	logic [15:0] seed = 16'hac31;
	logic [15:0] r;
	logic [13:0] st = 14'h0001;
	logic [7:0] d;
	wire [27:0] outs = {pll_power_down_out, pll_running_out, div_bypass_out, src_internal_osc_out,
		src_ext_clk_out, pfd_negative_out, abl_width_out, cp_hiz_out, cp_normal_out, cp_force_up_out,
		cp_force_down_out, cp_current_code_out, cp_current_ua_out};
	pcp_cfg_top u_pcp_cfg_top (.*);
	// Clock
	always #4 mclk_in = ~mclk_in;
	// Compare tasks
	task chk_bus(input [33:0] g, input [33:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %0t: bus %h exp %h", $time, g, e);
		end
	endtask
	task chk_out(input [27:0] g, input [27:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %0t: outputs %h exp %h", $time, g, e);
		end
	endtask
	// Random source
	function [15:0] lf(input [15:0] s);
		lf = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Control outputs expected from an active status word
	function [27:0] exp_out(input [13:0] s);
		logic [2:0] m;
		m = s[4:2];
		exp_out = {s[1:0] != 2'h0, s[1:0] == 2'h0, s[6], s[7], !s[7], s[5] & !s[7], s[9:8],
			m == 3'h0 || m > 3'h3, m == 3'h3, m == 3'h1, m == 3'h2, s[13:11], 13'h258 * (s[13:11] + 13'h1)};
	endfunction
	// Bus writer with noted answer
	task automatic wr(input [11:0] a, input [31:0] dt, input [1:0] e);
		@(posedge mclk_in);
		exp_q.push_back({e, 32'h0});
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= dt;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(posedge mclk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while (!s_axi_bvalid_out);
		s_axi_bready_in <= 1'b0;
	endtask
	// Bus reader with noted answer
	task automatic rd(input [11:0] a, input [33:0] e);
		@(posedge mclk_in);
		exp_q.push_back(e);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			@(posedge mclk_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
		end while (!s_axi_rvalid_out);
		s_axi_rready_in <= 1'b0;
	endtask
	// Result watcher
	always @(posedge mclk_in) begin
		if (s_axi_bvalid_out && s_axi_bready_in) chk_bus({s_axi_bresp_out, 32'h0}, exp_q.pop_front());
		if (s_axi_rvalid_out && s_axi_rready_in) chk_bus({s_axi_rresp_out, s_axi_rdata_out}, exp_q.pop_front());
		if (vco_cal_start_out) pulses++;
	end
	// Verdict
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#100000;
		miscompares++;
		conclude;
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge mclk_in);
		rst_in <= 1'b0;
		rd(12'hc04, {20'h0, st});
		chk_out(outs, exp_out(st));
		wr(12'h004, 32'h1, 2'h2);
		rd(12'h004, 34'h200000000);
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			seed = lf(seed);
			r = seed;
			d = {r[7], i[2:0], r[3:0]};
			wr(12'h040, {24'h0, d}, 2'h0);
			wr(12'h784, {30'h0, r[9:8]}, 2'h0);
			wr(12'h05c, {30'h0, r[11:10]}, 2'h0);
			wr(12'hc00, {29'h0, r[14:12]}, 2'h0);
			wr(12'hc04, 32'hffff, 2'h0);
			wr(12'h8c8, 32'h2, 2'h0);
			rd(12'hc04, {20'h0, st});
			rd(12'h040, {26'h0, d & 8'hf3});
			wr(12'h8c8, 32'h1, 2'h0);
			st = {r[14:12], 1'b0, r[11:8], d[7], d[6:4], d[1:0]};
			rd(12'hc04, {20'h0, st});
			chk_out(outs, exp_out(st));
		end
		$display("test fields done");
		// Internal oscillator through the running divider before calibrating
		wr(12'h784, 32'h2, 2'h0);
		for (i = 0; i < 4; i++) begin
			wr(12'h060, {31'h0, i != 2}, 2'h0);
			wr(12'h8c8, 32'h1, 2'h0);
			repeat (3) @(posedge mclk_in);
			chk_bus({2'h0, 32'(pulses)}, (i == 3) ? 34'h2 : 34'h1);
		end
		$display("test calibration done");
		// Low frequency external source: PLL on, divider skipped
		wr(12'h040, 32'h0, 2'h0);
		wr(12'h784, 32'h1, 2'h0);
		s_axi_wstrb_in <= 4'he;
		wr(12'h040, 32'hff, 2'h0);
		s_axi_wstrb_in <= 4'hf;
		wr(12'h8c8, 32'h1, 2'h0);
		rd(12'h040, 34'h0);
		st = {st[13:11], 1'b1, st[9:8], 8'h40};
		rd(12'hc04, {20'h0, st});
		chk_out(outs, exp_out(st));
		$display("test low frequency bypass done");
		conclude;
	end
endmodule // pcp_cfg_top_test
